// [core/light_sensor_pkg.sv]
// constants shared by the light sensor mode control design
package light_sensor_pkg;

    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam int unsigned REG_IDX_W      = 4;
    localparam int unsigned IDX_LSB        = 2;
    localparam logic [3:0]  IDX_POWER      = 4'h0;
    localparam logic [3:0]  IDX_RESET      = 4'h1;
    localparam logic [3:0]  IDX_INTEG      = 4'h2;
    localparam logic [3:0]  IDX_ALERT_SEL  = 4'h3;
    localparam logic [3:0]  IDX_LEVEL_LO   = 4'h4;
    localparam logic [3:0]  IDX_LEVEL_HI   = 4'h5;
    localparam logic [3:0]  IDX_READING_LO = 4'h6;
    localparam logic [3:0]  IDX_READING_HI = 4'h7;
    localparam logic [3:0]  IDX_ID_LO      = 4'h8;
    localparam logic [3:0]  IDX_ID_HI      = 4'h9;

    // ------------------------------------------------------------
    // register values and reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  PWR_DOWN       = 8'h00;
    localparam logic [7:0]  PWR_ON         = 8'h08;
    localparam logic [7:0]  PWR_TEST1      = 8'h09;
    localparam logic [7:0]  PWR_TEST2      = 8'h0A;
    localparam logic [7:0]  PWR_TEST3      = 8'h0B;
    localparam logic [7:0]  RST_READING    = 8'h10;
    localparam logic [7:0]  RST_DEFAULT    = 8'h00;
    localparam logic [7:0]  INTEG_DEFAULT  = 8'h02;
    localparam logic [7:0]  INTEG_CODE_MAX = 8'h07;
    localparam logic [7:0]  SEL_RISE       = 8'h01;
    localparam logic [7:0]  SEL_FALL       = 8'h02;
    localparam logic [7:0]  SEL_OFF        = 8'h03;
    localparam logic [7:0]  LEVEL_LO_DEF   = 8'h00;
    localparam logic [7:0]  LEVEL_HI_DEF   = 8'h08;
    localparam logic [15:0] TEST2_READING  = 16'h5555;
    localparam logic [15:0] TEST3_READING  = 16'hAAAA;
    localparam logic [15:0] COUNT_MAX      = 16'hFFFF;
    localparam logic [15:0] COUNT_ZERO     = 16'h0000;
    localparam int unsigned CODE_W         = 3;

    // ------------------------------------------------------------
    // bus answers
    // ------------------------------------------------------------
    localparam logic [1:0]  RESP_OKAY      = 2'b00;
    localparam logic [1:0]  RESP_SLVERR    = 2'b10;
    localparam logic [23:0] PAD_ZERO       = 24'h00_0000;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned INTEG_MAX_MS   = 800;
    localparam int unsigned MS_PER_S       = 1000;
    localparam int unsigned OSC_HZ_DEF     = 1_000_000;
    localparam int unsigned TIMER_W        = 20;

endpackage

// [core/sync_two_ff.sv]
// two flip-flop synchroniser for levels entering a clock domain
module sync_two_ff #(
    parameter int unsigned W = 1
) (
    input  wire logic         clk,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] stage_reg;

    always_ff @(posedge clk)
    begin
        stage_reg <= d;
    end

    always_ff @(posedge clk)
    begin
        q <= stage_reg;
    end

endmodule // sync_two_ff

// [core/integration_timer.sv]
// integration period timer on the oscillator clock
module integration_timer #(
    parameter int unsigned                      CNT_W      = 20,
    parameter logic [CNT_W-1:0]                 MAX_CYCLES = 20'h0_0001
) (
    input  wire logic                           clk,
    input  wire logic                           rstN,
    input  wire logic                           run,
    input  wire logic [light_sensor_pkg::CODE_W-1:0] code,
    output logic                                done
);

    logic [CNT_W-1:0] period;
    logic [CNT_W-1:0] cnt_reg;

    // each code step halves the period
    assign period = MAX_CYCLES >> code;

    always_ff @(posedge clk)
    begin
        if (!rstN || !run)
        begin
            cnt_reg <= '0;
            done    <= 1'b0;
        end
        else if (cnt_reg >= period - 1'b1)
        begin
            cnt_reg <= '0;
            done    <= 1'b1;
        end
        else
        begin
            cnt_reg <= cnt_reg + 1'b1;
            done    <= 1'b0;
        end
    end

endmodule // integration_timer

// [core/light_sensor_mode_control.sv]
// light sensor measurement and mode control behind an AXI4-Lite slave
//
// Overview of operation
// - integrate light into unsigned 16-bit saturating count
// - hand each result to register side
// - count grows with integration time and intensity
// - software writes select interrupt, polling or power-down
// - alert pin asserts when count exceeds level with SEL_FALL, when it does not with SEL_RISE
// - polling: continuous measurement, latest count readable
// - power-down stops measuring, releases alert pin
// - power-down keeps every register value
// - bus stays active to accept power-on
// - 0x00 powers down, 0x08 powers on
// - 3-bit code selects 800 ms down to 6.25 ms
// - open-drain alert with programmable sense
// - alert level low byte 0x04, high 0x05
module light_sensor_mode_control #(
    parameter int unsigned ADDR_W           = 8,
    parameter int unsigned OSC_HZ           = light_sensor_pkg::OSC_HZ_DEF,
    parameter int unsigned INTEG_MAX_CYCLES =
        light_sensor_pkg::INTEG_MAX_MS * OSC_HZ / light_sensor_pkg::MS_PER_S,
    // arbitrary identification value
    parameter logic [15:0] DEVICE_ID        = 16'h00A5
) (
    input  wire logic              ref_clk,
    input  wire logic              nrst,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]        s_axi_awprot,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]        s_axi_arprot,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              osc_clk,
    input  wire logic              photonIn,
    output logic                   alertOut,
    output logic                   alertDriveN
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    localparam logic [light_sensor_pkg::TIMER_W-1:0] MAX_CYC =
        light_sensor_pkg::TIMER_W'(INTEG_MAX_CYCLES);

    logic [3:0]  awIdx_reg;
    logic        awHeld_reg;
    logic [7:0]  wByte_reg;
    logic        wLane_reg;
    logic        wHeld_reg;
    logic        doWrite;
    logic        wrMapped;
    logic [3:0]  arIdx;
    logic [7:0]  readByte;
    logic        readMapped;

    logic [7:0]  powerCtl_reg;
    logic [7:0]  integCode_reg;
    logic [7:0]  alertSel_reg;
    logic [7:0]  alert_level_low_byte_reg;
    logic [7:0]  alert_level_high_byte_reg;
    logic [15:0] ambient_light_reading_reg;
    logic        compare_reg;
    logic        above_reg;
    logic        poweredOn;
    logic        clearReading;

    logic [3:0]  cfgToOsc;
    logic [3:0]  cfgOsc;
    logic        oscRstN;
    logic        photonSync;
    logic        intDone;
    logic [15:0] output_count_reg;
    logic [15:0] resultHold_reg;
    logic        resultTgl_reg;
    logic        resultTglSync;
    logic        resultTglSeen_reg;
    logic        newResult;

    // ------------------------------------------------------------
    // write channel
    // ------------------------------------------------------------
    assign doWrite  = awHeld_reg && wHeld_reg && !s_axi_bvalid;
    assign wrMapped = awIdx_reg <= light_sensor_pkg::IDX_ID_HI;

    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            s_axi_awready <= 1'b1;
            awHeld_reg    <= 1'b0;
            awIdx_reg     <= '0;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            s_axi_awready <= 1'b0;
            awHeld_reg    <= 1'b1;
            awIdx_reg     <= s_axi_awaddr[light_sensor_pkg::IDX_LSB +: 4];
        end
        else if (doWrite)
        begin
            awHeld_reg    <= 1'b0;
        end
        else if (s_axi_bvalid && s_axi_bready)
        begin
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            s_axi_wready <= 1'b1;
            wHeld_reg    <= 1'b0;
            wByte_reg    <= '0;
            wLane_reg    <= 1'b0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            s_axi_wready <= 1'b0;
            wHeld_reg    <= 1'b1;
            wByte_reg    <= s_axi_wdata[7:0];
            wLane_reg    <= s_axi_wstrb[0];
        end
        else if (doWrite)
        begin
            wHeld_reg    <= 1'b0;
        end
        else if (s_axi_bvalid && s_axi_bready)
        begin
            s_axi_wready <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= light_sensor_pkg::RESP_OKAY;
        end
        else if (doWrite)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wrMapped ? light_sensor_pkg::RESP_OKAY
                                     : light_sensor_pkg::RESP_SLVERR;
        end
        else if (s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    function automatic logic wrHit(input logic [3:0] idx);
        wrHit = doWrite && wLane_reg && (awIdx_reg == idx);
    endfunction

    // bus logic keeps running in power-down
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
            powerCtl_reg <= light_sensor_pkg::PWR_ON;
        else if (wrHit(light_sensor_pkg::IDX_POWER))
        begin
            unique case (wByte_reg)
                light_sensor_pkg::PWR_DOWN,
                light_sensor_pkg::PWR_ON,
                light_sensor_pkg::PWR_TEST1,
                light_sensor_pkg::PWR_TEST2,
                light_sensor_pkg::PWR_TEST3:
                    powerCtl_reg <= wByte_reg;
                default:
                    powerCtl_reg <= light_sensor_pkg::PWR_ON;
            endcase
        end
    end

    assign poweredOn = powerCtl_reg != light_sensor_pkg::PWR_DOWN;

    assign clearReading = wrHit(light_sensor_pkg::IDX_RESET)
                       && (wByte_reg == light_sensor_pkg::RST_READING);

    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
            integCode_reg <= light_sensor_pkg::INTEG_DEFAULT;
        else if (wrHit(light_sensor_pkg::IDX_INTEG))
            integCode_reg <= (wByte_reg <= light_sensor_pkg::INTEG_CODE_MAX)
                           ? wByte_reg
                           : light_sensor_pkg::INTEG_DEFAULT;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
            alertSel_reg <= light_sensor_pkg::SEL_OFF;
        else if (wrHit(light_sensor_pkg::IDX_ALERT_SEL))
        begin
            unique case (wByte_reg)
                light_sensor_pkg::SEL_RISE,
                light_sensor_pkg::SEL_FALL,
                light_sensor_pkg::SEL_OFF:
                    alertSel_reg <= wByte_reg;
                default:
                    alertSel_reg <= light_sensor_pkg::SEL_OFF;
            endcase
        end
    end

    // level bytes are never touched by power state
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            alert_level_low_byte_reg  <= light_sensor_pkg::LEVEL_LO_DEF;
            alert_level_high_byte_reg <= light_sensor_pkg::LEVEL_HI_DEF;
        end
        else
        begin
            if (wrHit(light_sensor_pkg::IDX_LEVEL_LO))
                alert_level_low_byte_reg  <= wByte_reg;
            if (wrHit(light_sensor_pkg::IDX_LEVEL_HI))
                alert_level_high_byte_reg <= wByte_reg;
        end
    end

    // ------------------------------------------------------------
    // read channel
    // ------------------------------------------------------------
    assign arIdx = s_axi_araddr[light_sensor_pkg::IDX_LSB +: 4];

    always_comb
    begin
        readByte   = '0;
        readMapped = 1'b1;
        case (arIdx)
            light_sensor_pkg::IDX_POWER:      readByte = powerCtl_reg;
            light_sensor_pkg::IDX_RESET:
                readByte = light_sensor_pkg::RST_DEFAULT;
            light_sensor_pkg::IDX_INTEG:      readByte = integCode_reg;
            light_sensor_pkg::IDX_ALERT_SEL:  readByte = alertSel_reg;
            light_sensor_pkg::IDX_LEVEL_LO:
                readByte = alert_level_low_byte_reg;
            light_sensor_pkg::IDX_LEVEL_HI:
                readByte = alert_level_high_byte_reg;
            light_sensor_pkg::IDX_READING_LO:
                readByte = ambient_light_reading_reg[7:0];
            light_sensor_pkg::IDX_READING_HI:
                readByte = ambient_light_reading_reg[15:8];
            light_sensor_pkg::IDX_ID_LO:      readByte = DEVICE_ID[7:0];
            light_sensor_pkg::IDX_ID_HI:      readByte = DEVICE_ID[15:8];
            default:                          readMapped = 1'b0;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= light_sensor_pkg::RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= {light_sensor_pkg::PAD_ZERO, readByte};
            s_axi_rresp   <= readMapped ? light_sensor_pkg::RESP_OKAY
                                        : light_sensor_pkg::RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // crossing into the oscillator domain
    // ------------------------------------------------------------
    assign cfgToOsc = {poweredOn, integCode_reg[light_sensor_pkg::CODE_W-1:0]};

    sync_two_ff #(.W(4)) cfgSync (
        .clk (osc_clk),
        .d   (cfgToOsc),
        .q   (cfgOsc)
    );

    sync_two_ff #(.W(1)) rstSync (
        .clk (osc_clk),
        .d   (nrst),
        .q   (oscRstN)
    );

    sync_two_ff #(.W(1)) photonSyncU (
        .clk (osc_clk),
        .d   (photonIn),
        .q   (photonSync)
    );

    // ------------------------------------------------------------
    // measurement on the oscillator clock
    // ------------------------------------------------------------
    integration_timer #(
        .CNT_W      (light_sensor_pkg::TIMER_W),
        .MAX_CYCLES (MAX_CYC)
    ) intTimer (
        .clk  (osc_clk),
        .rstN (oscRstN),
        .run  (cfgOsc[3]),
        .code (cfgOsc[2:0]),
        .done (intDone)
    );

    // photon cycles accumulate over the period
    always_ff @(posedge osc_clk)
    begin
        if (!oscRstN || !cfgOsc[3])
            output_count_reg <= light_sensor_pkg::COUNT_ZERO;
        else if (intDone)
            output_count_reg <= 16'(photonSync);
        else if (photonSync
              && output_count_reg != light_sensor_pkg::COUNT_MAX)
            output_count_reg <= output_count_reg + 1'b1;
    end

    // result is held stable while its toggle crosses
    always_ff @(posedge osc_clk)
    begin
        if (!oscRstN)
        begin
            resultHold_reg <= light_sensor_pkg::COUNT_ZERO;
            resultTgl_reg  <= 1'b0;
        end
        else if (intDone)
        begin
            resultHold_reg <= output_count_reg;
            resultTgl_reg  <= !resultTgl_reg;
        end
    end

    // ------------------------------------------------------------
    // result arrival in the register domain
    // ------------------------------------------------------------
    sync_two_ff #(.W(1)) tglSync (
        .clk (ref_clk),
        .d   (resultTgl_reg),
        .q   (resultTglSync)
    );

    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
            resultTglSeen_reg <= 1'b0;
        else
            resultTglSeen_reg <= resultTglSync;
    end

    assign newResult = (resultTglSync != resultTglSeen_reg) && poweredOn;

    // arriving result wins over a clear in the same cycle
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
            ambient_light_reading_reg <= light_sensor_pkg::COUNT_ZERO;
        else if (newResult)
        begin
            unique case (powerCtl_reg)
                light_sensor_pkg::PWR_TEST2:
                    ambient_light_reading_reg <=
                        light_sensor_pkg::TEST2_READING;
                light_sensor_pkg::PWR_TEST3:
                    ambient_light_reading_reg <=
                        light_sensor_pkg::TEST3_READING;
                default:
                    ambient_light_reading_reg <= resultHold_reg;
            endcase
        end
        else if (clearReading)
            ambient_light_reading_reg <= light_sensor_pkg::COUNT_ZERO;
    end

    // ------------------------------------------------------------
    // alert decision and pin
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
            compare_reg <= 1'b0;
        else
            compare_reg <= newResult;
    end

    // compare follows the reading update by one cycle
    always_ff @(posedge ref_clk)
    begin
        if (!nrst || !poweredOn)
            above_reg <= 1'b0;
        else if (compare_reg)
            above_reg <= ambient_light_reading_reg >
                         {alert_level_high_byte_reg,
                          alert_level_low_byte_reg};
    end

    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
            alertOut <= 1'b0;
        else
            alertOut <= 1'b0;
    end

    // low enable pulls the pin low
    always_ff @(posedge ref_clk)
    begin
        if (!nrst || !poweredOn)
            alertDriveN <= 1'b1;
        else
        begin
            unique case (alertSel_reg)
                light_sensor_pkg::SEL_RISE:
                    alertDriveN <= above_reg;
                light_sensor_pkg::SEL_FALL:
                    alertDriveN <= !above_reg;
                default:
                    alertDriveN <= 1'b1;
            endcase
        end
    end

endmodule // light_sensor_mode_control

// [testbench/light_sensor_checker.sv]
// assertions on the bus and alert ports of the light sensor block
module light_sensor_checker (
    input wire logic        ref_clk,
    input wire logic        nrst,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        alertOut
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    aw_busy_a: assert property (s_axi_awvalid && s_axi_awready
        |=> !s_axi_awready) else $error("awready after accept");
    w_busy_a: assert property (s_axi_wvalid && s_axi_wready
        |=> !s_axi_wready) else $error("wready after accept");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("b dropped");
    b_done_a: assert property (s_axi_bvalid && s_axi_bready
        |=> !s_axi_bvalid && s_axi_awready) else $error("b not closed");
    r_next_a: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid && !s_axi_arready) else $error("no read answer");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("r dropped");
    r_pad_a: assert property (s_axi_rvalid
        |-> s_axi_rdata[31:8] == 24'h00_0000) else $error("rdata pad");
    od_low_a: assert property (1'b1 |-> !alertOut)
        else $error("alert data not low");
endmodule // light_sensor_checker

bind light_sensor_mode_control light_sensor_checker chk_u (.*);

// [testbench/axi_host.sv]
// bus master model standing in for the host controller
module axi_host (
    input  wire logic        ref_clk,
    output logic [7:0]       awaddr,
    output logic             awvalid,
    input  wire logic        awready,
    output logic [31:0]      wdata,
    output logic [3:0]       wstrb,
    output logic             wvalid,
    input  wire logic        wready,
    input  wire logic [1:0]  bresp,
    input  wire logic        bvalid,
    output logic             bready,
    output logic [7:0]       araddr,
    output logic             arvalid,
    input  wire logic        arready,
    input  wire logic [31:0] rdata,
    input  wire logic [1:0]  rresp,
    input  wire logic        rvalid,
    output logic             rready
);
    initial
    begin
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0000_0000;
        wstrb = 4'h1;
    end
    // mode and power writes
    task automatic wr(input logic [3:0] i, input logic [7:0] d,
                      output logic [1:0] resp);
        @(posedge ref_clk);
        awaddr <= {2'b00, i, 2'b00};
        wdata <= {24'h00_0000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge ref_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!(bvalid && bready));
        resp = bresp;
        bready <= 1'b0;
    endtask
    // count read at the host's own pace
    task automatic rd(input logic [3:0] i, output logic [31:0] d,
                      output logic [1:0] resp);
        @(posedge ref_clk);
        araddr <= {2'b00, i, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge ref_clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!(rvalid && rready));
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask
endmodule // axi_host

// [testbench/tb_light_sensor_mode_control.sv]
// self-checking bench for the light sensor mode control
module tb_light_sensor_mode_control;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int unsigned MAXC = 256;
    localparam int LIMIT = 20000;
    logic        ref_clk = 1'b0, osc_clk = 1'b0, nrst = 1'b0;
    logic        photonIn = 1'b0;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, rv;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, rs;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, alertOut, alertDriveN;
    int          failures = 0, compares = 0, cycles = 0;
    always #12.5 ref_clk = ~ref_clk;
    initial #3.1 forever #62.5 osc_clk = ~osc_clk;
    // arbitrary identification value
    light_sensor_mode_control #(.INTEG_MAX_CYCLES(MAXC),
        .DEVICE_ID(16'h00C3)) dut_u (.ref_clk(ref_clk), .nrst(nrst),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'b000),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'b000), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .osc_clk(osc_clk),
        .photonIn(photonIn), .alertOut(alertOut),
        .alertDriveN(alertDriveN));
    axi_host host_u (.ref_clk(ref_clk), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready));
    task automatic conclude();
        $display("failures=%0d compares=%0d", failures, compares);
        if (failures == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, g);
        compares++;
        if (g !== e)
        begin
            failures++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic w(input logic [3:0] i, input logic [7:0] d);
        host_u.wr(i, d, rs);
        chk("bresp", 0, rs);
    endtask
    task automatic r(input logic [3:0] i, output logic [7:0] d);
        host_u.rd(i, rv, rs);
        chk("rresp", 0, rs);
        d = rv[7:0];
    endtask
    task automatic t_defaults();
        logic [7:0] e [10] = '{8'h08, 8'h00, 8'h02, 8'h03, 8'h00, 8'h08,
                               8'h00, 8'h00, 8'hC3, 8'h00};
        logic [7:0] d;
        for (int i = 0; i < 10; i++)
        begin
            r(i[3:0], d);
            chk("default", e[i], d);
        end
        host_u.rd(4'hA, rv, rs);
        chk("unmapped", light_sensor_pkg::RESP_SLVERR, rs);
    endtask
    task automatic t_invalid();
        logic [19:0] tv [3] = '{20'h2_0902, 20'h3_0003, 20'h0_0508};
        logic [7:0] d;
        foreach (tv[k])
        begin
            w(tv[k][19:16], tv[k][15:8]);
            r(tv[k][19:16], d);
            chk("fallback", tv[k][7:0], {24'h00_0000, d});
        end
    endtask
    task automatic t_count();
        logic [7:0] c [3] = '{8'h07, 8'h04, 8'h00};
        logic [7:0] lo, hi;
        @(posedge ref_clk) photonIn <= 1'b1;
        foreach (c[k])
        begin
            w(4'h2, c[k]);
            repeat ((MAXC >> c[k]) * 15 + 40) @(posedge ref_clk);
            r(4'h6, lo);
            r(4'h7, hi);
            chk("reading", MAXC >> c[k], {hi, lo});
        end
    endtask
    task automatic t_alert();
        logic [15:0] st [7] = '{16'h3010, 16'h5001, 16'h3020, 16'h4021,
                                16'h4010, 16'h3031, 16'h3020};
        w(4'h2, 8'h07);
        repeat (1400) @(posedge ref_clk);
        foreach (st[k])
        begin
            w(st[k][15:12], st[k][11:4]);
            repeat (60) @(posedge ref_clk);
            chk("alertDriveN", st[k][3:0], alertDriveN);
        end
    endtask
    task automatic t_power();
        logic [7:0] d;
        w(4'h0, 8'h00);
        repeat (60) @(posedge ref_clk);
        chk("alertDriveN", 1, alertDriveN);
        r(4'h4, d);
        chk("level kept", 32'h0000_0001, d);
        w(4'h1, 8'h10);
        r(4'h6, d);
        chk("cleared", 32'h0000_0000, d);
        w(4'h0, 8'h0A);
        repeat (60) @(posedge ref_clk);
        r(4'h7, d);
        chk("test reading", 32'h0000_0055, d);
        w(4'h0, 8'h08);
        repeat (60) @(posedge ref_clk);
        r(4'h6, d);
        chk("reading on", 32'h0000_0002, d);
        chk("alertDriveN", 0, alertDriveN);
    endtask
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            failures++;
            conclude();
        end
    end
    initial
    begin
        repeat (16) @(posedge ref_clk);
        nrst <= 1'b1;
        t_defaults();
        t_invalid();
        t_count();
        t_alert();
        t_power();
        conclude();
    end
endmodule // tb_light_sensor_mode_control
